// >>> logic/voc_pin_drive.sv
// Pin driver: turns register settings into pin levels and enables.
// Assumes settings arrive on the same clock; outputs are registered.
`timescale 1ns/1ns
module voc_pin_drive (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  voc_pin_if.drv    pins
);

  logic fmt_ok;   // Format lets general outputs through
  logic [3:0] en; // Per-pin driver enable

  assign fmt_ok = voc_pkg::GPO_FMT_MASK[pins.fmt];

  // ------------------------------------------------------------
  // General output pins
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_gpo
      // Pair enables gate each pin; format gates them all
      if (g < 2) begin : gen_low
        assign en[g] = fmt_ok & pins.low_en; // R4 R5
      end else begin : gen_high
        assign en[g] = fmt_ok & pins.high_en; // R4 R6
      end
      // Registered pin level and enable
      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          pins.gpo_oe[g]  <= 1'b0;
          pins.gpo_out[g] <= 1'b0;
        end else begin
          pins.gpo_oe[g] <= en[g];
          // Pin 0 may carry lock status instead
          if (g == 0 && pins.line_lock) begin
            pins.gpo_out[g] <= pins.hlock; // R8
          end else begin
            pins.gpo_out[g] <= pins.gpo_bits[g]; // R4
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Data and extra pin enables
  // ------------------------------------------------------------
  // Force bit overrides the external enable pin
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pins.data_oe  <= 1'b0;
      pins.extra_oe <= 1'b0;
    end else begin
      pins.data_oe  <= !pins.force_hiz && !pins.oe_n_sync; // R18
      pins.extra_oe <= (pins.extra_sel != 3'h0); // R3
    end
  end

endmodule

// >>> logic/voc_pin_if.sv
// Interface between the register bank and its pin driver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface voc_pin_if;
  logic [3:0] gpo_bits;    // Programmed general output values
  logic       low_en;      // Drivers for outputs 0 and 1
  logic       high_en;     // Drivers for outputs 2 and 3
  logic       line_lock;   // Output 0 carries horizontal lock
  logic       hlock;       // Horizontal lock status
  logic [3:0] fmt;         // Output format selection
  logic       force_hiz;   // Data drivers off
  logic       oe_n_sync;   // Synchronised output enable pin
  logic [2:0] extra_sel;   // Extra pin data selection
  logic [3:0] gpo_out;     // General output pin levels
  logic [3:0] gpo_oe;      // General output pin enables
  logic       extra_oe;    // Extra data pins enable
  logic       data_oe;     // Main data pins enable

  modport ctrl (output gpo_bits, low_en, high_en, line_lock, hlock, fmt,
                force_hiz, oe_n_sync, extra_sel,
                input gpo_out, gpo_oe, extra_oe, data_oe);
  modport drv  (input gpo_bits, low_en, high_en, line_lock, hlock, fmt,
                force_hiz, oe_n_sync, extra_sel,
                output gpo_out, gpo_oe, extra_oe, data_oe);
endinterface

// >>> logic/voc_pkg.sv
// Package for the video output control register bank.
// Assumes an APB master with 32-bit data and word-aligned registers.
package voc_pkg;

  // ------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_ENHANCE  = 6'h02; // Peaking and luma floor
  localparam logic [5:0] IDX_OUT_CTRL = 6'h03; // Format, hi-z, passthru
  localparam logic [5:0] IDX_EXTRAS   = 6'h04; // output_format_extras
  localparam logic [5:0] IDX_GPO      = 6'h05; // general_output_ctrl
  localparam logic [5:0] IDX_FIFO     = 6'h07; // fifo_control
  localparam logic [5:0] IDX_CONTRAST = 6'h08; // contrast_level
  localparam logic [5:0] IDX_SAT      = 6'h09; // saturation_level
  localparam logic [5:0] IDX_BRIGHT   = 6'h0a; // brightness_level
  localparam logic [5:0] IDX_HUE      = 6'h0b; // hue_angle

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ENHANCE  = 8'h04; // Peaking at no change
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_EXTRAS   = 8'h0c; // Fixed bits 3:1 = 110
  localparam logic [7:0] RST_GPO      = 8'h00;
  localparam logic [4:0] RST_MARGIN   = 5'h04;
  localparam logic [7:0] RST_CONTRAST = 8'h80; // Unity gain
  localparam logic [7:0] RST_SAT      = 8'h80; // 0 dB
  localparam logic [7:0] RST_BRIGHT   = 8'h00; // No offset
  localparam logic [7:0] RST_HUE      = 8'h00; // 0 degrees

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int EXT_RANGE_BIT = 0;
  localparam logic [2:0] EXT_FIXED = 3'h6; // Fixed pattern in bits 3:1
  localparam int EXT_SEL_LSB   = 4;
  localparam int EXT_BT4_BIT   = 7;
  localparam int GPO_LOW_BIT   = 4;
  localparam int GPO_HIGH_BIT  = 5;
  localparam int GPO_BLANK_BIT = 6;
  localparam int GPO_LOCK_BIT  = 7;
  localparam int FIFO_FR_BIT   = 5;
  localparam int FIFO_AFR_BIT  = 6;
  localparam int FIFO_FST_BIT  = 7;
  localparam int OC_FMT_LSB    = 2;
  localparam int OC_HIZ_BIT    = 6;
  localparam int OC_VBI_BIT    = 7;
  localparam int EN_FLOOR_LSB  = 3;

  // ------------------------------------------------------------
  // Luma floor thresholds in codes above black
  // ------------------------------------------------------------
  localparam logic [5:0] FLOOR_OFF = 6'h00;
  localparam logic [5:0] FLOOR_8   = 6'h08;
  localparam logic [5:0] FLOOR_16  = 6'h10;
  localparam logic [5:0] FLOOR_32  = 6'h20;

  // Output formats in which general outputs may be driven
  localparam logic [15:0] GPO_FMT_MASK = 16'h001f;

endpackage

// >>> logic/voc_regs.sv
// Video output control register bank with APB slave.
// Assumes a same-clock APB master; OUTPUT_EN_N is an asynchronous pin.
//
// How it works
// [R1] Range bit selects compliant or full codes
// [R2] Mode bit picks older or newer timing codes
// [R3] Zero extra-pin select leaves twelve pins hi-z
// [R4] General outputs drive only in allowed formats
// [R5] Low-pair enable drives pins zero and one
// [R6] High-pair enable drives pins two and three
// [R7] Chroma blank replaces colour during vertical blanking
// [R8] Line-lock makes pin zero show lock status
// [R9] Five-bit margin places nearly-empty/full flags
// [R10] Flush bit resets FIFO, then self-clears
// [R11] Per-field flush resets FIFO each field end
// [R12] Flag timing bit chooses pixel or core clock
// [R13] Contrast value sets luma gain
// [R14] Saturation value sets chroma gain
// [R15] Brightness value offsets video level
// [R16] Hue value rotates colour phase
// [R17] Passthrough lets blanking lines skip filtering
// [R18] Force bit tri-states data regardless of pin
// [R19] Peaking select shapes luma near subcarrier
// [R20] Floor select truncates luma near black
// [R21] Passthrough is bit seven of output control
// [R22] Software writes fixed bits and enables first
`timescale 1ns/1ns
module voc_regs (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        HLOCK,
  input  wire logic        VBLANK,
  input  wire logic        VBI_LINE,
  input  wire logic        FIELD_END,
  input  wire logic        OUTPUT_EN_N,
  output logic      [3:0]  GPO_OUT,
  output logic      [3:0]  GPO_OE,
  output logic             EXTRA_PIN_OE,
  output logic             DATA_OE,
  output logic             FULL_RANGE,
  output logic             BT656_4_MODE,
  output logic      [2:0]  EXTRA_PIN_DATA_SELECT,
  output logic             CHROMA_BLANK,
  output logic             FIFO_FLUSH,
  output logic      [4:0]  FIFO_FLAG_MARGIN,
  output logic             FLAG_CLK_INTERNAL,
  output logic      [7:0]  LUMA_GAIN,
  output logic      [7:0]  CHROMA_GAIN,
  output logic      [7:0]  LUMA_OFFSET,
  output logic      [7:0]  HUE_ANGLE,
  output logic             FILTER_BYPASS,
  output logic      [2:0]  LUMA_PEAKING,
  output logic      [5:0]  LUMA_FLOOR,
  output logic      [3:0]  OUTPUT_FORMAT,
  output logic      [1:0]  OUTPUT_MODE
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0] enhance;      // Peaking and floor selection
  logic [7:0] out_ctrl;     // Mode, format, force hi-z, passthru
  logic [7:0] extras;       // output_format_extras
  logic [7:0] gpo_ctrl;     // general_output_ctrl
  logic [4:0] flag_margin;  // FIFO flag margin
  logic       per_field;    // Per-field flush enable
  logic       flag_src;     // Flag timing source
  logic [7:0] contrast;     // contrast_level
  logic [7:0] saturation;   // saturation_level
  logic [7:0] brightness;   // brightness_level
  logic [7:0] hue;          // hue_angle

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic [5:0] idx;          // Word index
  logic       mapped;       // Address hits a register
  logic       wr;           // Write takes effect this edge
  logic       setup;        // Setup phase of any transfer
  logic       wr_flush;     // Software flush request
  logic [7:0] next_rdata;   // Read value for this address

  assign idx   = PADDR[7:2];
  assign setup = PSEL && !PENABLE;
  assign wr    = PSEL && PENABLE && PWRITE && mapped;
  assign wr_flush = wr && idx == voc_pkg::IDX_FIFO
                    && PWDATA[voc_pkg::FIFO_FR_BIT];

  // No wait states: every access finishes in one access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Map lookup and read mux; misaligned addresses are unmapped
  always_comb begin
    mapped     = (PADDR[1:0] == 2'h0);
    next_rdata = 8'h00;
    case (idx)
      voc_pkg::IDX_ENHANCE:  next_rdata = enhance;
      voc_pkg::IDX_OUT_CTRL: next_rdata = out_ctrl;
      voc_pkg::IDX_EXTRAS:   next_rdata = extras;
      voc_pkg::IDX_GPO:      next_rdata = gpo_ctrl;
      voc_pkg::IDX_FIFO:     next_rdata = {flag_src, per_field,
                                           FIFO_FLUSH, flag_margin};
      voc_pkg::IDX_CONTRAST: next_rdata = contrast;
      voc_pkg::IDX_SAT:      next_rdata = saturation;
      voc_pkg::IDX_BRIGHT:   next_rdata = brightness;
      voc_pkg::IDX_HUE:      next_rdata = hue;
      default:               mapped     = 1'b0;
    endcase
  end

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      PRDATA <= {24'h00_0000, next_rdata};
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Plain read/write registers
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      enhance    <= voc_pkg::RST_ENHANCE;
      out_ctrl   <= voc_pkg::RST_OUT_CTRL;
      gpo_ctrl   <= voc_pkg::RST_GPO;
      contrast   <= voc_pkg::RST_CONTRAST;
      saturation <= voc_pkg::RST_SAT;
      brightness <= voc_pkg::RST_BRIGHT;
      hue        <= voc_pkg::RST_HUE;
    end else if (wr) begin
      case (idx)
        voc_pkg::IDX_ENHANCE:  enhance    <= PWDATA[7:0]; // R19 R20
        voc_pkg::IDX_OUT_CTRL: out_ctrl   <= PWDATA[7:0]; // R21
        voc_pkg::IDX_GPO:      gpo_ctrl   <= PWDATA[7:0];
        voc_pkg::IDX_CONTRAST: contrast   <= PWDATA[7:0]; // R13
        voc_pkg::IDX_SAT:      saturation <= PWDATA[7:0]; // R14
        voc_pkg::IDX_BRIGHT:   brightness <= PWDATA[7:0]; // R15
        voc_pkg::IDX_HUE:      hue        <= PWDATA[7:0]; // R16
        default: ;
      endcase
    end
  end

  // Extras: fixed bits always read back as their set pattern
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      extras <= voc_pkg::RST_EXTRAS;
    end else if (wr && idx == voc_pkg::IDX_EXTRAS) begin
      extras <= {PWDATA[7:4], voc_pkg::EXT_FIXED, PWDATA[0]};
    end
  end

  // FIFO control settings
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      flag_margin <= voc_pkg::RST_MARGIN;
      per_field   <= 1'b0;
      flag_src    <= 1'b0;
    end else if (wr && idx == voc_pkg::IDX_FIFO) begin
      flag_margin <= PWDATA[4:0]; // R9
      per_field   <= PWDATA[voc_pkg::FIFO_AFR_BIT];
      flag_src    <= PWDATA[voc_pkg::FIFO_FST_BIT];
    end
  end

  // ------------------------------------------------------------
  // FIFO flush pulse
  // ------------------------------------------------------------
  // One-cycle pulse; reads back as the flush bit, so it self-clears
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      FIFO_FLUSH <= 1'b0;
    end else begin
      FIFO_FLUSH <= wr_flush || (per_field && FIELD_END); // R10 R11
    end
  end

  // ------------------------------------------------------------
  // Video-facing settings, registered
  // ------------------------------------------------------------
  // Blanking-dependent controls follow the line timing inputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      CHROMA_BLANK  <= 1'b0;
      FILTER_BYPASS <= 1'b0;
    end else begin
      CHROMA_BLANK  <= gpo_ctrl[voc_pkg::GPO_BLANK_BIT] && VBLANK; // R7
      FILTER_BYPASS <= out_ctrl[voc_pkg::OC_VBI_BIT] && VBI_LINE; // R17
    end
  end

  // Floor threshold decode; zero disables truncation
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      LUMA_FLOOR <= voc_pkg::FLOOR_OFF;
    end else begin
      case (enhance[voc_pkg::EN_FLOOR_LSB +: 2])
        2'h1:    LUMA_FLOOR <= voc_pkg::FLOOR_8; // R20
        2'h2:    LUMA_FLOOR <= voc_pkg::FLOOR_16;
        2'h3:    LUMA_FLOOR <= voc_pkg::FLOOR_32;
        default: LUMA_FLOOR <= voc_pkg::FLOOR_OFF;
      endcase
    end
  end

  // Direct settings are already flops
  assign FULL_RANGE        = extras[voc_pkg::EXT_RANGE_BIT]; // R1
  assign BT656_4_MODE      = extras[voc_pkg::EXT_BT4_BIT]; // R2
  assign EXTRA_PIN_DATA_SELECT = extras[voc_pkg::EXT_SEL_LSB +: 3];
  assign FIFO_FLAG_MARGIN  = flag_margin; // R9
  assign FLAG_CLK_INTERNAL = flag_src; // R12
  assign LUMA_GAIN         = contrast;
  assign CHROMA_GAIN       = saturation;
  assign LUMA_OFFSET       = brightness;
  assign HUE_ANGLE         = hue;
  assign LUMA_PEAKING      = enhance[2:0]; // R19
  assign OUTPUT_MODE       = out_ctrl[1:0];
  assign OUTPUT_FORMAT     = out_ctrl[voc_pkg::OC_FMT_LSB +: 4];

  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  logic oe_n_meta;  // First synchroniser stage, read only below
  logic oe_n_sync;  // Safe to use

  // Two flops: the enable pin is asynchronous to the core clock
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      oe_n_meta <= 1'b1;
      oe_n_sync <= 1'b1;
    end else begin
      oe_n_meta <= OUTPUT_EN_N;
      oe_n_sync <= oe_n_meta;
    end
  end

  voc_pin_if pins ();

  assign pins.gpo_bits  = gpo_ctrl[3:0];
  assign pins.low_en    = gpo_ctrl[voc_pkg::GPO_LOW_BIT];
  assign pins.high_en   = gpo_ctrl[voc_pkg::GPO_HIGH_BIT];
  assign pins.line_lock = gpo_ctrl[voc_pkg::GPO_LOCK_BIT];
  assign pins.hlock     = HLOCK;
  assign pins.fmt       = OUTPUT_FORMAT;
  assign pins.force_hiz = out_ctrl[voc_pkg::OC_HIZ_BIT];
  assign pins.oe_n_sync = oe_n_sync;
  assign pins.extra_sel = EXTRA_PIN_DATA_SELECT;

  voc_pin_drive u_drive (
    .CORE_CLK (CORE_CLK),
    .RESET    (RESET),
    .pins     (pins.drv)
  );

  assign GPO_OUT      = pins.gpo_out;
  assign GPO_OE       = pins.gpo_oe;
  assign EXTRA_PIN_OE = pins.extra_oe;
  assign DATA_OE      = pins.data_oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  logic fmt_ok;  // Helper for the pin checks
  assign fmt_ok = voc_pkg::GPO_FMT_MASK[OUTPUT_FORMAT];

  a_flush_pulse: assert property ( // R10
    wr_flush |=> FIFO_FLUSH)
    else $error("flush write gave no pulse");
  a_flush_cause: assert property ( // R11
    FIFO_FLUSH |-> $past(wr_flush || (per_field && FIELD_END)))
    else $error("flush pulse without cause");
  a_field_flush: assert property ( // R11
    per_field && FIELD_END |=> FIFO_FLUSH)
    else $error("field end did not flush");
  a_chroma_blank: assert property ( // R7
    gpo_ctrl[voc_pkg::GPO_BLANK_BIT] && VBLANK |=> CHROMA_BLANK)
    else $error("chroma not blanked");
  a_low_pair_hiz: assert property ( // R5
    !pins.low_en |=> GPO_OE[1:0] == 2'h0)
    else $error("low pair driven while disabled");
  a_high_pair_on: assert property ( // R6
    pins.high_en && fmt_ok |=> GPO_OE[3:2] == 2'h3)
    else $error("high pair not driven");
  a_line_lock_pin: assert property ( // R8
    pins.line_lock && pins.low_en && fmt_ok
      |=> GPO_OUT[0] == $past(HLOCK) && GPO_OE[0])
    else $error("pin 0 not showing lock");
  a_force_hiz: assert property ( // R18
    pins.force_hiz |=> !DATA_OE)
    else $error("data driven while forced off");
  a_extra_hiz: assert property ( // R3
    EXTRA_PIN_DATA_SELECT == 3'h0 |=> !EXTRA_PIN_OE)
    else $error("extra pins driven with no data");
  a_gain_write: assert property ( // R13
    wr && idx == voc_pkg::IDX_CONTRAST |=> LUMA_GAIN == $past(PWDATA[7:0]))
    else $error("contrast write lost");
  a_floor_decode: assert property ( // R20
    enhance[4:3] == 2'h3 ##1 enhance[4:3] == 2'h3
      |-> LUMA_FLOOR == voc_pkg::FLOOR_32)
    else $error("floor threshold wrong");

  // Gating checked both ways for pin pairs and flush; chroma blank, filter bypass, force hi-z and extra pins one way only
  a_flush_clear: assert property ( // R10
    FIFO_FLUSH && !wr_flush && !(per_field && FIELD_END) |=> !FIFO_FLUSH)
    else $error("flush bit stuck");
  a_low_pair_on: assert property ( // R5
    pins.low_en && fmt_ok |=> GPO_OE[1:0] == 2'h3)
    else $error("low pair not driven");
  a_high_pair_hiz: assert property ( // R6
    !pins.high_en |=> GPO_OE[3:2] == 2'h0)
    else $error("high pair driven while disabled");
  a_format_gate: assert property ( // R4
    !fmt_ok |=> GPO_OE == 4'h0)
    else $error("outputs driven in bad format");
  a_vbi_bypass: assert property ( // R17
    out_ctrl[voc_pkg::OC_VBI_BIT] && VBI_LINE |=> FILTER_BYPASS)
    else $error("blanking line not bypassed");
  a_margin_write: assert property ( // R9
    wr && idx == voc_pkg::IDX_FIFO |=> flag_margin == $past(PWDATA[4:0]))
    else $error("margin write lost");

  c_soft_flush: cover property (wr_flush ##1 FIFO_FLUSH ##1 !FIFO_FLUSH);
  c_field_flush: cover property (per_field && FIELD_END ##1 FIFO_FLUSH);
  c_lock_pin: cover property (pins.line_lock && pins.low_en && fmt_ok);
  c_bad_addr: cover property (PSLVERR);

endmodule

// >>> tb/video_output_control_regs_bench.sv
// Self-checking bench for the video output control register bank.
// Assumes voc_pkg is compiled first and the sink model drives timing.
`timescale 1ns/1ns
module video_output_control_regs_bench;
  logic        CORE_CLK, RESET, PSEL, PENABLE, PWRITE, OUTPUT_EN_N;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR, HLOCK, VBLANK, VBI_LINE, FIELD_END;
  logic [3:0]  GPO_OUT, GPO_OE, OUTPUT_FORMAT, f, g;
  logic        EXTRA_PIN_OE, DATA_OE, FULL_RANGE, BT656_4_MODE;
  logic        CHROMA_BLANK, FIFO_FLUSH, FLAG_CLK_INTERNAL, FILTER_BYPASS;
  logic [2:0]  EXTRA_PIN_DATA_SELECT, LUMA_PEAKING, s;
  logic [4:0]  FIFO_FLAG_MARGIN, m;
  logic [7:0]  LUMA_GAIN, CHROMA_GAIN, LUMA_OFFSET, HUE_ANGLE, v, b, c, h;
  logic [5:0]  LUMA_FLOOR;
  logic [1:0]  OUTPUT_MODE;
  logic        lock_req, blank_req, vbi_req, field_req;
  int          err_count, comparisons, flushes, i, n0;
  logic [32:0] exp_q[$]; // Expected {slverr, rdata} per transfer
  localparam logic [7:0] BND [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};

  voc_regs i_dut (.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HLOCK, .VBLANK, .VBI_LINE,
    .FIELD_END, .OUTPUT_EN_N, .GPO_OUT, .GPO_OE, .EXTRA_PIN_OE, .DATA_OE,
    .FULL_RANGE, .BT656_4_MODE, .EXTRA_PIN_DATA_SELECT, .CHROMA_BLANK,
    .FIFO_FLUSH, .FIFO_FLAG_MARGIN, .FLAG_CLK_INTERNAL, .LUMA_GAIN,
    .CHROMA_GAIN, .LUMA_OFFSET, .HUE_ANGLE, .FILTER_BYPASS, .LUMA_PEAKING,
    .LUMA_FLOOR, .OUTPUT_FORMAT, .OUTPUT_MODE);
  voc_video_sink i_sink (.CORE_CLK, .RESET, .lock_req, .blank_req,
    .vbi_req, .field_req, .FIFO_FLUSH, .HLOCK, .VBLANK, .VBI_LINE,
    .FIELD_END, .flushes);

  always #5 CORE_CLK = ~CORE_CLK; // 100 MHz

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; releases the bus after pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 16) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    apb(1'b1, {ix, 2'b00}, d, 33'h0);
  endtask

  task automatic rd(input logic [5:0] ix, input logic [31:0] e);
    apb(1'b0, {ix, 2'b00}, 32'h0, {1'b0, e});
  endtask

  // Let this edge's updates land, then look
  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  // Monitor: each completed transfer takes the oldest note
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
      else begin
        chk("pslverr", exp_q[0][32], PSLVERR);
        if (!PWRITE) chk("prdata", exp_q[0][31:0], PRDATA);
        void'(exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {CORE_CLK, PSEL, PENABLE, PWRITE, PADDR, PWDATA, OUTPUT_EN_N} = '0;
    {lock_req, blank_req, vbi_req, field_req} = '0;
    {err_count, comparisons} = '0;
    RESET = 1'b1;
    void'($urandom(70));
    repeat (6) @(posedge CORE_CLK);
    RESET <= 1'b0;
    rd(voc_pkg::IDX_ENHANCE, voc_pkg::RST_ENHANCE);
    rd(voc_pkg::IDX_EXTRAS, voc_pkg::RST_EXTRAS);
    rd(voc_pkg::IDX_FIFO, {27'h0, voc_pkg::RST_MARGIN});
    rd(voc_pkg::IDX_SAT, voc_pkg::RST_SAT);
    settle(2);
    chk("extra_oe", 1'b0, EXTRA_PIN_OE);
    chk("gpo_oe", 4'h0, GPO_OE);
    chk("data_oe", 1'b1, DATA_OE);
    // Picture controls: boundary codes, then one random value
    for (i = 0; i < 5; i++) begin
      v = (i < 4) ? BND[i] : 8'($urandom);
      b = ~v;
      c = v ^ 8'h55;
      h = v + 8'h01;
      wr(voc_pkg::IDX_CONTRAST, v);
      wr(voc_pkg::IDX_SAT, b);
      wr(voc_pkg::IDX_BRIGHT, c);
      wr(voc_pkg::IDX_HUE, h);
      settle(2);
      chk("luma_gain", v, LUMA_GAIN);
      chk("chroma_gain", b, CHROMA_GAIN);
      chk("luma_offset", c, LUMA_OFFSET);
      chk("hue", h, HUE_ANGLE);
      rd(voc_pkg::IDX_BRIGHT, c);
    end
    // Every extra-pin code; last one writes the fixed bits wrongly
    for (i = 0; i < 8; i++) begin
      s = i[2:0];
      wr(voc_pkg::IDX_EXTRAS, {s[1], s, (i == 7) ? 3'h0 : 3'h6, s[0]});
      settle(2);
      chk("full_range", s[0], FULL_RANGE);
      chk("bt656_4", s[1], BT656_4_MODE);
      chk("extra_sel", s, EXTRA_PIN_DATA_SELECT);
      chk("extra_oe", s != 3'h0, EXTRA_PIN_OE);
      rd(voc_pkg::IDX_EXTRAS, {s[1], s, 3'h6, s[0]});
    end
    // General outputs across allowed and disallowed formats
    for (i = 0; i < 12; i++) begin
      f = (i < 4) ? 4'h0 : (i < 8) ? 4'h4 : 4'h5;
      g = 4'($urandom);
      wr(voc_pkg::IDX_OUT_CTRL, {26'h0, f, i[3:2]});
      wr(voc_pkg::IDX_GPO, {26'h0, i[1:0], g});
      settle(2);
      chk("format", f, OUTPUT_FORMAT);
      chk("mode", i[3:2], OUTPUT_MODE);
      chk("gpo_oe", (f == 4'h5) ? 4'h0 : {{2{i[1]}}, {2{i[0]}}}, GPO_OE);
      if (f != 4'h5) chk("gpo_out", g, GPO_OUT);
    end
    wr(voc_pkg::IDX_OUT_CTRL, 32'h0);
    wr(voc_pkg::IDX_GPO, 32'h91);
    for (i = 0; i < 2; i++) begin
      @(posedge CORE_CLK);
      lock_req <= i[0];
      settle(3);
      chk("lock_pin", i[0], GPO_OUT[0]);
      chk("lock_oe", 1'b1, GPO_OE[0]);
    end
    // Chroma blank, filter bypass and forced hi-z against their inputs
    for (i = 0; i < 4; i++) begin
      wr(voc_pkg::IDX_OUT_CTRL, {24'h0, i[1], 7'h0});
      wr(voc_pkg::IDX_GPO, {24'h0, 1'b0, i[1], 6'h0});
      @(posedge CORE_CLK);
      blank_req <= i[0];
      vbi_req   <= i[0];
      settle(3);
      chk("chroma_blank", i[0] & i[1], CHROMA_BLANK);
      chk("filter_bypass", i[0] & i[1], FILTER_BYPASS);
      wr(voc_pkg::IDX_OUT_CTRL, {25'h0, i[1], 6'h0});
      @(posedge CORE_CLK);
      OUTPUT_EN_N <= i[0];
      settle(4);
      chk("data_oe", !(i[0] | i[1]), DATA_OE);
    end
    // Peaking and every luma floor code
    for (i = 0; i < 4; i++) begin
      s = 3'($urandom);
      wr(voc_pkg::IDX_ENHANCE, {27'h0, i[1:0], s});
      settle(2);
      chk("peaking", s, LUMA_PEAKING);
      chk("floor", (i == 0) ? 6'h00 : 6'(6'h04 << i), LUMA_FLOOR);
    end
    // Software flush pulse and self-clearing bit
    for (i = 0; i < 2; i++) begin
      m = 5'($urandom);
      wr(voc_pkg::IDX_FIFO, {24'h0, i[0], 2'b01, m});
      #1;
      chk("flush_on", 1'b1, FIFO_FLUSH);
      settle(1);
      chk("flush_off", 1'b0, FIFO_FLUSH);
      chk("margin", m, FIFO_FLAG_MARGIN);
      chk("flag_clk", i[0], FLAG_CLK_INTERNAL);
      rd(voc_pkg::IDX_FIFO, {24'h0, i[0], 2'b00, m});
    end
    // End-of-field flush only while enabled
    for (i = 0; i < 2; i++) begin
      wr(voc_pkg::IDX_FIFO, {24'h0, 1'b0, ~i[0], 6'h04});
      n0 = flushes;
      @(posedge CORE_CLK);
      field_req <= 1'b1;
      @(posedge CORE_CLK);
      field_req <= 1'b0;
      settle(4);
      chk("auto_flush", n0 + (i == 0), flushes);
    end
    // Unmapped and misaligned places are refused
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h21, 32'hff, {1'b1, 32'h0});
    rd(voc_pkg::IDX_CONTRAST, v);
    wrap_up();
  end
endmodule

// >>> tb/voc_video_sink.sv
// Downstream video processor model: timing source and flush sink.
// Assumes the bank's clock; the bench steers it through request inputs.
`timescale 1ns/1ns
module voc_video_sink (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  input  wire logic lock_req,
  input  wire logic blank_req,
  input  wire logic vbi_req,
  input  wire logic field_req,
  input  wire logic FIFO_FLUSH,
  output logic      HLOCK,
  output logic      VBLANK,
  output logic      VBI_LINE,
  output logic      FIELD_END,
  output int        flushes
);
  // ----------------------------------------
  // Timing outputs
  // ----------------------------------------
  // Registered, so they change just after an edge like a real core
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      HLOCK     <= 1'b0;
      VBLANK    <= 1'b0;
      VBI_LINE  <= 1'b0;
      FIELD_END <= 1'b0;
    end else begin
      HLOCK     <= lock_req;
      VBLANK    <= blank_req;
      VBI_LINE  <= vbi_req;
      FIELD_END <= field_req; // One cycle per end of field
    end
  end

  // Each pulse empties our input FIFO; software never clears it here
  always_ff @(posedge CORE_CLK) begin
    if (RESET) flushes <= 0;
    else if (FIFO_FLUSH) flushes <= flushes + 1;
  end
endmodule
